// file: rtl/ubc_pkg.sv
package break_unit_pkg;

  localparam logic [5:0] OFS_BREAK_ADDR_A  = 6'h00;
  localparam logic [5:0] OFS_ADDR_MASK_A   = 6'h04;
  localparam logic [5:0] OFS_BUS_COND_A    = 6'h08;
  localparam logic [5:0] OFS_BREAK_ADDR_B  = 6'h0C;
  localparam logic [5:0] OFS_ADDR_MASK_B   = 6'h10;
  localparam logic [5:0] OFS_BREAK_DATA_B  = 6'h14;
  localparam logic [5:0] OFS_DATA_MASK_B   = 6'h18;
  localparam logic [5:0] OFS_BUS_COND_B    = 6'h1C;
  localparam logic [5:0] OFS_BREAK_CONTROL = 6'h20;
  localparam logic [5:0] OFS_TRACE         = 6'h24;

  localparam int BC_BUS_LSB  = 0;
  localparam int BC_ACC_LSB  = 2;
  localparam int BC_RW_LSB   = 4;
  localparam int BC_SIZE_LSB = 6;
  localparam int BC_XYE_BIT  = 8;
  localparam int BC_XYS_BIT  = 9;
  localparam logic [31:0] BC_WRITE_MASK = 32'h0000_03FF;

  localparam int CTL_CORE_A_BIT = 0;
  localparam int CTL_SYS_A_BIT  = 1;
  localparam int CTL_CORE_B_BIT = 2;
  localparam int CTL_SYS_B_BIT  = 3;
  localparam int CTL_TRACE_BIT  = 4;

  localparam int TRACE_VALID_BIT = 31;
  localparam int TRACE_ADDR_W    = 28;
  localparam int TRACE_DEPTH     = 8;

  localparam logic [31:0] REG_RST      = 32'h0000_0000;
  localparam logic [2:0]  CTRL_REGION  = 3'h7;

  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  typedef struct packed {
    logic        valid;
    logic        fetch;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] data;
  } bus_cycle_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        sel_y;
    logic [15:0] addr;
    logic [15:0] data;
  } xy_cycle_s;

endpackage

// file: rtl/user_break_match_and_branch_trace.sv
// Functional notes
// - Read-only 32-bit trace register holds branch target address bits 27..0.
// - Bit 31 valid flag set to 1 whenever a target is captured.
// - Valid flag cleared by reading out the last valid entry, by enabling tracing, or by reset.
// - Captured address bits are not reset; only the valid flag is.
// - Eight trace entries form a last-in first-out stack shifting on every branch taken while tracing is enabled.
// - Trace bits 30..28 read as zero; software writes them as zero.
// - No break on a channel when its bus, access or read/write group is 00; size 00 matches any size.
// - A channel match requests a break and sets its match flags.
// - X/Y memory bus matches on channel B set its core-bus flag.
// - Match flags are sticky; only a software write of 0 or reset clears them.
// - Simultaneous matches on both channels give a single break request.
// - System bus conditions watch cycles of every master, DMA included.
// - System bus compares physical addresses; control region passes unchanged.
// - Uncached data keeps size; uncached fetches are rounded longwords.
// - Cache fills and write-backs are rounded longwords; write-through misses are not.
// - CPU fetch cycles count as fetches; all others, DMA included, as data.
// - System bus breaks give no guarantee which instruction takes them.
// - With the CPU block bit set, no break is sent but flags still set.
//
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps

module user_break_match_and_branch_trace
  import break_unit_pkg::*;
#(
  parameter int DEPTH = TRACE_DEPTH
) (
  input  wire logic        clk_sys,          // Core clock, 40 MHz
  input  wire logic        nrst,             // Power-on reset, active low
  input  wire logic        clk_en,           // Freezes all state but the reset synchronizer while low
  input  wire logic [5:0]  avs_address,      // Byte address
  input  wire logic        avs_read,         // Read request
  input  wire logic        avs_write,        // Write request
  input  wire logic [31:0] avs_writedata,    // Write data
  input  wire logic [3:0]  avs_byteenable,   // Byte lanes
  output logic      [31:0] avs_readdata,     // Read data
  output logic             avs_waitrequest,  // Stall the master
  input  wire bus_cycle_s  core_cycle,       // Core-side bus cycle
  input  wire bus_cycle_s  sys_cycle,        // System bus cycle, any master
  input  wire xy_cycle_s   xy_cycle,         // X/Y memory bus cycle
  input  wire logic        cpu_block,        // CPU status block bit
  input  wire logic        branch_taken,     // One pulse per taken branch
  input  wire logic [31:0] branch_target,    // Branch destination address
  output logic             break_request     // One-cycle break pulse to CPU
);

  logic       rst_meta_reg;
  logic       rst_n_sync;
  logic       ack_reg;
  logic       rd_done;
  logic       wr_done;

  logic [31:0] bar_a_reg;
  logic [31:0] bamr_a_reg;
  logic [31:0] cond_a_reg;
  logic [31:0] bar_b_reg;
  logic [31:0] bamr_b_reg;
  logic [31:0] bdr_b_reg;
  logic [31:0] bdmr_b_reg;
  logic [31:0] cond_b_reg;
  logic        trace_en_reg;
  logic [3:0]  flags_reg;
  logic [3:0]  flags_next;

  logic [TRACE_ADDR_W-1:0] taddr_reg [DEPTH];
  logic [DEPTH-1:0]        tvalid_reg;
  logic [DEPTH-1:0]        tvalid_next;

  bus_cycle_s sys_phys;
  logic       hit_core_a;
  logic       hit_sys_a;
  logic       hit_core_b;
  logic       hit_sys_b;
  logic       trace_on;
  logic       trace_pop;
  logic       trace_push;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync   <= rst_meta_reg;
    end
  end

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic addr_hit(input logic [31:0] a,
                                    input logic [31:0] bar,
                                    input logic [31:0] mask,
                                    input logic [1:0]  sz);
    logic [31:0] ign;
    ign = mask;
    if (sz == SZ_LONG) begin
      ign[1:0] = 2'h3;
    end else if (sz == SZ_WORD) begin
      ign[0] = 1'b1;
    end
    return ((a ^ bar) & ~ign) == 32'h0000_0000;
  endfunction

  function automatic logic cond_hit(input logic [31:0] cond,
                                    input logic        on_sys,
                                    input logic        fetch,
                                    input logic        write,
                                    input logic [1:0]  sz);
    logic [1:0] bsel;
    logic [1:0] acc;
    logic [1:0] rw;
    logic [1:0] csz;
    bsel = cond[BC_BUS_LSB +: 2];
    acc  = cond[BC_ACC_LSB +: 2];
    rw   = cond[BC_RW_LSB +: 2];
    csz  = cond[BC_SIZE_LSB +: 2];
    return (bsel != 2'h0) && (acc != 2'h0) && (rw != 2'h0)
        && bsel[on_sys] && acc[!fetch] && rw[write]
        && ((csz == 2'h0) || (csz == sz + 2'h1));
  endfunction

  function automatic logic data_hit(input logic [31:0] d,
                                    input logic [31:0] bdr,
                                    input logic [31:0] bdmr,
                                    input logic [1:0]  sz);
    logic [31:0] diff;
    diff = (d ^ bdr) & ~bdmr;
    if (sz != SZ_LONG) begin
      diff[31:16] = 16'h0000;
    end
    return diff == 32'h0000_0000;
  endfunction

  function automatic logic [31:0] phys_addr(input logic [31:0] a);
    logic [31:0] p;
    p = a;
    if (a[31:29] != CTRL_REGION) begin
      p[31:29] = 3'h0;
    end
    return p;
  endfunction

  // The bus already rounds fills, write-backs and uncached fetches to
  // longwords, so the size-aware compare below simply ignores the low
  // address bits those cycles carry.
  // size follows cycle
  always_comb begin
    sys_phys      = sys_cycle;
    sys_phys.addr = phys_addr(sys_cycle.addr);
    if (sys_cycle.size == SZ_LONG) begin
      sys_phys.addr[1:0] = 2'h0;
    end
  end

  logic data_on_b;
  assign data_on_b = (cond_b_reg[BC_ACC_LSB +: 2] == 2'h2)
                  && (cond_b_reg[BC_SIZE_LSB +: 2] != 2'h0);

  assign hit_core_a = core_cycle.valid
                   && cond_hit(cond_a_reg, 1'b0, core_cycle.fetch,
                               core_cycle.write, core_cycle.size)
                   && addr_hit(core_cycle.addr, bar_a_reg, bamr_a_reg,
                               core_cycle.size);

  assign hit_sys_a = sys_phys.valid
                  && cond_hit(cond_a_reg, 1'b1, sys_phys.fetch,
                              sys_phys.write, sys_phys.size)
                  && addr_hit(sys_phys.addr, bar_a_reg, bamr_a_reg,
                              sys_phys.size);

  logic        xy_hit;
  logic [15:0] xy_bar;
  logic [15:0] xy_mask;
  logic [15:0] xy_bdr;
  logic [15:0] xy_bdmr;
  assign xy_bar  = xy_cycle.sel_y ? bar_b_reg[15:0]  : bar_b_reg[31:16];
  assign xy_mask = xy_cycle.sel_y ? bamr_b_reg[15:0] : bamr_b_reg[31:16];
  assign xy_bdr  = xy_cycle.sel_y ? bdr_b_reg[15:0]  : bdr_b_reg[31:16];
  assign xy_bdmr = xy_cycle.sel_y ? bdmr_b_reg[15:0] : bdmr_b_reg[31:16];

  assign xy_hit = xy_cycle.valid
               && (xy_cycle.sel_y == cond_b_reg[BC_XYS_BIT])
               && cond_hit(cond_b_reg, 1'b0, 1'b0, xy_cycle.write, SZ_WORD)
               && (((xy_cycle.addr ^ xy_bar) & ~xy_mask) == 16'h0000)
               && (!data_on_b
                   || (((xy_cycle.data ^ xy_bdr) & ~xy_bdmr) == 16'h0000));

  always_comb begin
    if (cond_b_reg[BC_XYE_BIT]) begin
      hit_core_b = xy_hit;
    end else begin
      hit_core_b = core_cycle.valid
                && cond_hit(cond_b_reg, 1'b0, core_cycle.fetch,
                            core_cycle.write, core_cycle.size)
                && addr_hit(core_cycle.addr, bar_b_reg, bamr_b_reg,
                            core_cycle.size)
                && (!data_on_b
                    || data_hit(core_cycle.data, bdr_b_reg, bdmr_b_reg,
                                core_cycle.size));
    end
  end

  assign hit_sys_b = sys_phys.valid
                  && cond_hit(cond_b_reg, 1'b1, sys_phys.fetch,
                              sys_phys.write, sys_phys.size)
                  && addr_hit(sys_phys.addr, bar_b_reg, bamr_b_reg,
                              sys_phys.size)
                  && (!data_on_b
                      || data_hit(sys_phys.data, bdr_b_reg, bdmr_b_reg,
                                  sys_phys.size));

  // One wait state: the request is taken on the second edge it is seen.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign rd_done = avs_read && ack_reg && clk_en;
  assign wr_done = avs_write && ack_reg && clk_en;

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      ack_reg <= 1'b0;
    end else if (clk_en) begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      avs_readdata <= REG_RST;
    end else if (clk_en && avs_read && !ack_reg) begin
      if (avs_address == OFS_BREAK_ADDR_A) begin
        avs_readdata <= bar_a_reg;
      end else if (avs_address == OFS_ADDR_MASK_A) begin
        avs_readdata <= bamr_a_reg;
      end else if (avs_address == OFS_BUS_COND_A) begin
        avs_readdata <= cond_a_reg;
      end else if (avs_address == OFS_BREAK_ADDR_B) begin
        avs_readdata <= bar_b_reg;
      end else if (avs_address == OFS_ADDR_MASK_B) begin
        avs_readdata <= bamr_b_reg;
      end else if (avs_address == OFS_BREAK_DATA_B) begin
        avs_readdata <= bdr_b_reg;
      end else if (avs_address == OFS_DATA_MASK_B) begin
        avs_readdata <= bdmr_b_reg;
      end else if (avs_address == OFS_BUS_COND_B) begin
        avs_readdata <= cond_b_reg;
      end else if (avs_address == OFS_BREAK_CONTROL) begin
        avs_readdata <= {27'h0, trace_en_reg, flags_reg};
      end else if (avs_address == OFS_TRACE) begin
        avs_readdata <= {tvalid_reg[0], 3'h0, taddr_reg[0]};
      end else begin
        avs_readdata <= REG_RST;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      bar_a_reg    <= REG_RST;
      bamr_a_reg   <= REG_RST;
      cond_a_reg   <= REG_RST;
      bar_b_reg    <= REG_RST;
      bamr_b_reg   <= REG_RST;
      bdr_b_reg    <= REG_RST;
      bdmr_b_reg   <= REG_RST;
      cond_b_reg   <= REG_RST;
      trace_en_reg <= 1'b0;
    end else if (wr_done) begin
      if (avs_address == OFS_BREAK_ADDR_A) begin
        bar_a_reg <= merge_bytes(bar_a_reg, avs_writedata, avs_byteenable);
      end else if (avs_address == OFS_ADDR_MASK_A) begin
        bamr_a_reg <= merge_bytes(bamr_a_reg, avs_writedata, avs_byteenable);
      end else if (avs_address == OFS_BUS_COND_A) begin
        cond_a_reg <= merge_bytes(cond_a_reg, avs_writedata, avs_byteenable)
                    & BC_WRITE_MASK;
      end else if (avs_address == OFS_BREAK_ADDR_B) begin
        bar_b_reg <= merge_bytes(bar_b_reg, avs_writedata, avs_byteenable);
      end else if (avs_address == OFS_ADDR_MASK_B) begin
        bamr_b_reg <= merge_bytes(bamr_b_reg, avs_writedata, avs_byteenable);
      end else if (avs_address == OFS_BREAK_DATA_B) begin
        bdr_b_reg <= merge_bytes(bdr_b_reg, avs_writedata, avs_byteenable);
      end else if (avs_address == OFS_DATA_MASK_B) begin
        bdmr_b_reg <= merge_bytes(bdmr_b_reg, avs_writedata, avs_byteenable);
      end else if (avs_address == OFS_BUS_COND_B) begin
        cond_b_reg <= merge_bytes(cond_b_reg, avs_writedata, avs_byteenable)
                    & BC_WRITE_MASK;
      end else if (avs_address == OFS_BREAK_CONTROL && avs_byteenable[0]) begin
        trace_en_reg <= avs_writedata[CTL_TRACE_BIT];
      end
    end
  end

  always_comb begin
    flags_next = flags_reg;
    if (wr_done && avs_address == OFS_BREAK_CONTROL && avs_byteenable[0]) begin
      flags_next = flags_reg & avs_writedata[3:0];
    end
    flags_next[CTL_CORE_A_BIT] = flags_next[CTL_CORE_A_BIT] | hit_core_a;
    flags_next[CTL_SYS_A_BIT]  = flags_next[CTL_SYS_A_BIT]  | hit_sys_a;
    flags_next[CTL_CORE_B_BIT] = flags_next[CTL_CORE_B_BIT] | hit_core_b;
    flags_next[CTL_SYS_B_BIT]  = flags_next[CTL_SYS_B_BIT]  | hit_sys_b;
  end

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      flags_reg <= 4'h0;
    end else if (clk_en) begin
      flags_reg <= flags_next;
    end
  end

  // System bus hits reach the CPU a cycle later with no tie to the
  // instruction that caused them, so the CPU decides where it stops.
  // single merged request
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      break_request <= 1'b0;
    end else if (clk_en) begin
      break_request <= (hit_core_a || hit_sys_a || hit_core_b || hit_sys_b)
                    && !cpu_block;
    end
  end

  assign trace_on   = wr_done && avs_address == OFS_BREAK_CONTROL
                   && avs_byteenable[0] && avs_writedata[CTL_TRACE_BIT]
                   && !trace_en_reg;
  assign trace_pop  = rd_done && avs_address == OFS_TRACE;
  assign trace_push = branch_taken && trace_en_reg && clk_en;

  // Reading pops the newest entry so software walks back through history.
  // valid on capture
  always_comb begin
    tvalid_next = tvalid_reg;
    if (trace_on) begin
      tvalid_next = '0;
    end
    if (trace_push) begin
      tvalid_next = {tvalid_next[DEPTH-2:0], 1'b1};
      if (trace_pop) begin
        tvalid_next[1] = 1'b0;
      end
    end else if (trace_pop) begin
      tvalid_next = {1'b0, tvalid_next[DEPTH-1:1]};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      tvalid_reg <= '0;
    end else if (clk_en) begin
      tvalid_reg <= tvalid_next;
    end
  end

  // Address storage has no reset on purpose: it keeps old history.
  // address not reset
  always_ff @(posedge clk_sys) begin
    if (trace_push) begin
      taddr_reg[0] <= branch_target[TRACE_ADDR_W-1:0];
      for (int i = 1; i < DEPTH; i++) begin
        taddr_reg[i] <= taddr_reg[i-1];
      end
    end else if (trace_pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        taddr_reg[i] <= taddr_reg[i+1];
      end
    end
  end

endmodule

// file: dv/break_trace_properties.sv
`timescale 1ns/1ps

module break_trace_properties
  import break_unit_pkg::*;
#(
  parameter int DEPTH = 8
) (
  input wire logic        clk_sys,          // Clock
  input wire logic        nrst,             // Reset
  input wire logic        clk_en,           // Enable
  input wire logic [5:0]  avs_address,      // Address
  input wire logic        avs_read,         // Read
  input wire logic        avs_write,        // Write
  input wire logic [31:0] avs_readdata,     // Read data
  input wire logic        avs_waitrequest,  // Stall
  input wire bus_cycle_s  core_cycle,       // Core bus
  input wire bus_cycle_s  sys_cycle,        // System bus
  input wire xy_cycle_s   xy_cycle,         // X/Y bus
  input wire logic        cpu_block,        // Block bit
  input wire logic        branch_taken,     // Branch
  input wire logic        break_request     // Break
);
  logic [3:0] pops_reg;
  logic       rd_done;
  logic       any_valid;

  assign rd_done = avs_read && !avs_waitrequest;
  assign any_valid = core_cycle.valid || sys_cycle.valid || xy_cycle.valid;

  // Trace reads since the last branch; after DEPTH of them every entry has been popped.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pops_reg <= 4'(DEPTH);
    end else if (branch_taken) begin
      pops_reg <= 4'h0;
    end else if (rd_done && avs_address == OFS_TRACE && pops_reg < 4'(DEPTH)) begin
      pops_reg <= pops_reg + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus request waited too long");

  property p_wait_idle;
    !avs_read && !avs_write |-> !avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("waitrequest without a request");

  property p_two_cycles;
    (avs_read || avs_write) && !avs_waitrequest |-> $past(avs_waitrequest);
  endproperty
  a_two_cycles: assert property (p_two_cycles) else $error("access answered without a wait");

  property p_reserved;
    rd_done && avs_address == OFS_TRACE |-> avs_readdata[30:28] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("trace reserved bits not zero");

  property p_unmapped;
    rd_done && avs_address > OFS_TRACE |-> avs_readdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_block;
    cpu_block |=> !break_request;
  endproperty
  a_block: assert property (p_block) else $error("break sent while blocked");

  property p_cause;
    break_request |-> $past(any_valid);
  endproperty
  a_cause: assert property (p_cause) else $error("break without a bus cycle");

  property p_drained;
    rd_done && avs_address == OFS_TRACE && pops_reg >= 4'(DEPTH) |-> !avs_readdata[31];
  endproperty
  a_drained: assert property (p_drained) else $error("trace valid after full drain");
endmodule

// file: dv/far_side_model.sv
`timescale 1ns/1ps

module far_side_model
  import break_unit_pkg::*;
(
  input  wire logic   clk_sys,        // Clock
  output bus_cycle_s  core_cycle,     // Core bus
  output bus_cycle_s  sys_cycle,      // System bus
  output xy_cycle_s   xy_cycle,       // X/Y bus
  output logic        cpu_block,      // Block bit
  output logic        branch_taken,   // Branch pulse
  output logic [31:0] branch_target   // Branch address
);
  bus_cycle_s  p_core = '0;
  bus_cycle_s  p_sys  = '0;
  xy_cycle_s   p_xy   = '0;
  logic        p_br   = 1'b0;
  logic        blk    = 1'b0;
  logic [31:0] p_tgt  = '0;

  function automatic logic [31:0] phys(input logic [31:0] a);
    return (a[31:29] == CTRL_REGION) ? a : {3'h0, a[28:0]};
  endfunction

  // Idle payloads change every cycle so a stale value can never look like a real cycle.
  always @(posedge clk_sys) begin
    core_cycle <= p_core.valid ? p_core : {1'b0, 4'($urandom), $urandom, $urandom};
    sys_cycle <= p_sys.valid ? {p_sys[68:64], phys(p_sys.addr), p_sys.data}
                             : {1'b0, 4'($urandom), $urandom, $urandom};
    xy_cycle <= p_xy.valid ? p_xy : {1'b0, 2'($urandom), $urandom};
    branch_taken <= p_br;
    branch_target <= p_br ? p_tgt : $urandom;
    cpu_block <= blk;
    p_core.valid = 1'b0;
    p_sys.valid = 1'b0;
    p_xy.valid = 1'b0;
    p_br = 1'b0;
  end

  task automatic send(input bus_cycle_s c, input bus_cycle_s s, input xy_cycle_s x,
                      input logic br, input logic [31:0] t);
    @(negedge clk_sys);
    p_core = c;
    p_sys = s;
    p_xy = x;
    p_br = br;
    p_tgt = t;
    @(posedge clk_sys);
  endtask

  task automatic set_block(input logic b);
    @(negedge clk_sys);
    blk = b;
  endtask
endmodule

// file: dv/user_break_match_and_branch_trace_tb.sv
`timescale 1ns/1ps

module user_break_match_and_branch_trace_tb;
  import break_unit_pkg::*;
  localparam int DEPTH = 8;
  typedef struct packed {logic [31:0] m; logic [31:0] e;} note_s;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [5:0]  avs_address = '0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, branch_target;
  logic        avs_waitrequest, break_request, cpu_block, branch_taken;
  bus_cycle_s  core_cycle, sys_cycle;
  xy_cycle_s   xy_cycle;
  bus_cycle_s  nc = '0;
  xy_cycle_s   nx = '0;
  note_s       exp_q[$];
  note_s       cur;
  logic [31:0] tg[9];
  int          failures = 0;
  int          n_checks = 0;
  int          n_breaks = 0;

  initial forever #12.5 clk_sys = ~clk_sys;

  user_break_match_and_branch_trace #(.DEPTH(DEPTH)) DUT (.clk_sys(clk_sys), .nrst(nrst),
    .clk_en(1'b1), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .core_cycle(core_cycle), .sys_cycle(sys_cycle),
    .xy_cycle(xy_cycle), .cpu_block(cpu_block), .branch_taken(branch_taken),
    .branch_target(branch_target), .break_request(break_request));

  far_side_model u_far (.clk_sys(clk_sys), .core_cycle(core_cycle), .sys_cycle(sys_cycle),
    .xy_cycle(xy_cycle), .cpu_block(cpu_block), .branch_taken(branch_taken),
    .branch_target(branch_target));

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int   n;
    logic w;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(negedge clk_sys);
      w = avs_waitrequest;
      @(posedge clk_sys);
      n++;
    end while (w !== 1'b0 && n < 40);
    if (n >= 40) begin
      failures++;
      summarize();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    exp_q.push_back('{m, e});
    bus(1'b0, a, '0);
  endtask

  task automatic breaks(input int n);
    repeat (3) @(posedge clk_sys);
    chk(32'(n_breaks), 32'(n));
    n_breaks = 0;
  endtask

  function automatic bus_cycle_s cyc(input logic f, input logic w, input logic [31:0] a);
    return '{1'b1, f, w, SZ_LONG, a, $urandom};
  endfunction

  always @(negedge clk_sys) begin
    if (break_request === 1'b1) n_breaks++;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      cur = exp_q.pop_front();
      chk(avs_readdata & cur.m, cur.e);
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    summarize();
  end

  initial begin
    void'($urandom(32'h4924_0118));
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(OFS_BREAK_CONTROL, '0);
    rd(OFS_TRACE, '0, 32'hF000_0000);
    wr(6'h28, '1);
    rd(6'h28, '0);
    $display("test reset done");
    wr(OFS_BREAK_ADDR_A, 32'h0000_1000);
    wr(OFS_ADDR_MASK_A, '0);
    for (int g = 0; g < 4; g++) begin
      wr(OFS_BUS_COND_A, 32'h0000_0029 & ~(32'h0000_0003 << (2 * g)));
      u_far.send(cyc(1'b0, 1'b1, 32'h0000_1000), nc, nx, 1'b0, '0);
      breaks(g == 3);
    end
    rd(OFS_BREAK_CONTROL, 32'h0000_0001);
    $display("test groups done");
    u_far.send(cyc(1'b0, 1'b1, 32'h0000_2000), nc, nx, 1'b0, '0);
    breaks(0);
    wr(OFS_BREAK_CONTROL, 32'h0000_000F);
    rd(OFS_BREAK_CONTROL, 32'h0000_0001);
    wr(OFS_BREAK_CONTROL, '0);
    rd(OFS_BREAK_CONTROL, '0);
    u_far.set_block(1'b1);
    u_far.send(cyc(1'b0, 1'b1, 32'h0000_1000), nc, nx, 1'b0, '0);
    breaks(0);
    rd(OFS_BREAK_CONTROL, 32'h0000_0001);
    u_far.set_block(1'b0);
    wr(OFS_BREAK_CONTROL, '0);
    $display("test sticky done");
    wr(OFS_BUS_COND_A, 32'h0000_001A);
    u_far.send(nc, cyc(1'b1, 1'b0, 32'h8000_1000), nx, 1'b0, '0);
    breaks(0);
    u_far.send(nc, cyc(1'b0, 1'b0, 32'hE000_1000), nx, 1'b0, '0);
    breaks(0);
    // A DMA read issued at a logical address.
    u_far.send(nc, cyc(1'b0, 1'b0, 32'hA000_1000), nx, 1'b0, '0);
    breaks(1);
    rd(OFS_BREAK_CONTROL, 32'h0000_0002);
    wr(OFS_BREAK_CONTROL, '0);
    $display("test system bus done");
    wr(OFS_BUS_COND_A, 32'h0000_0029);
    wr(OFS_BREAK_ADDR_B, 32'h0000_2000);
    wr(OFS_ADDR_MASK_B, '0);
    wr(OFS_BUS_COND_B, 32'h0000_002A);
    u_far.send(cyc(1'b0, 1'b1, 32'h0000_1000), cyc(1'b0, 1'b1, 32'h0000_2000), nx, 1'b0, '0);
    breaks(1);
    rd(OFS_BREAK_CONTROL, 32'h0000_0009);
    wr(OFS_BREAK_CONTROL, '0);
    wr(OFS_BREAK_ADDR_B, 32'h0040_0000);
    wr(OFS_BUS_COND_B, 32'h0000_0119);
    u_far.send(nc, nc, '{1'b1, 1'b0, 1'b0, 16'h0040, 16'h1234}, 1'b0, '0);
    breaks(1);
    rd(OFS_BREAK_CONTROL, 32'h0000_0004);
    $display("test channels done");
    wr(OFS_BREAK_CONTROL, 32'h0000_0010);
    for (int i = 0; i < 9; i++) begin
      tg[i] = $urandom;
      u_far.send(nc, nc, nx, 1'b1, tg[i]);
    end
    // Let the last capture land first: a push between a read's two edges is popped unseen.
    repeat (2) @(posedge clk_sys);
    for (int i = 8; i > 0; i--) rd(OFS_TRACE, {4'h8, tg[i][27:0]});
    rd(OFS_TRACE, '0, 32'hF000_0000);
    $display("test trace queue done");
    u_far.send(nc, nc, nx, 1'b1, $urandom);
    wr(OFS_BREAK_CONTROL, '0);
    wr(OFS_BREAK_CONTROL, 32'h0000_0010);
    rd(OFS_TRACE, '0, 32'h8000_0000);
    $display("test trace enable done");
    repeat (3) @(posedge clk_sys);
    summarize();
  end
endmodule

bind user_break_match_and_branch_trace break_trace_properties #(.DEPTH(DEPTH)) u_props (
  .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .core_cycle(core_cycle), .sys_cycle(sys_cycle),
  .xy_cycle(xy_cycle), .cpu_block(cpu_block), .branch_taken(branch_taken),
  .break_request(break_request));
